// ---- rtl/sense_report_map.svh ----
// Register layout, field positions and command codes for the sense report block
// Functional notes
// - Sense report returns the triplet left by the latest executed command.
// - With sense data present, key, code and qualifier carry their standard values.
// - Without sense data, key, code and qualifier all read zero.
// - Sense reporting starts disabled after initialisation until the host enables it.
// - Each other command completing while no sense report is being accepted or running replaces the stored triplet with its own result.
// - Triplet cleared on reset, on acceptance of any command but sense report or a queued-error log page read, and after sense report.
// - On another command's completion, status bit 1 set when reporting is enabled, both identify enable bits are set and sense exists.
// - Error and sense-available status bits may be set together.
// - With either identify enable bit clear, status bit 1 carries no sense meaning.
// - Qualifier in sector number, code in cylinder low, key in cylinder high 3:0.
// - Error reports only aborted; busy, fault, corrected read zero; ready, index, error valid.
// - Sense reporting works independently of queued-command automatic sense.
`ifndef SENSE_REPORT_MAP_SVH
`define SENSE_REPORT_MAP_SVH
`define CMD_SENSE_REPORT     8'h0b
`define CMD_READ_LOG_EXT     8'h2f
`define LOG_PAGE_QUEUED_ERR  8'h10
`define DEVHEAD_FIXED_MASK   8'he0
`define ERR_ABORT_BIT        2
`define ST_ERR_BIT           0
`define ST_SENSE_BIT         1
`define ST_SEEK_BIT          4
`define ST_READY_BIT         6
`define IDENT_SENSE_BIT      6
`define KEY_W                4
`define CODE_W               8
`endif

// ---- rtl/sense_report_pkg.sv ----
// Types shared by the sense report block
package sense_report_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_DONE = 3'b100
    } cmd_state_t;
    typedef struct packed {
        logic [3:0] key;
        logic [7:0] code;
        logic [7:0] qual;
    } triplet_t;
endpackage : sense_report_pkg

// ---- rtl/sense_store_if.sv ----
// Carrier between command sequencer and triplet store
`timescale 1ns/1ps
interface sense_store_if;
    import sense_report_pkg::*;
    logic     load;
    logic     clear;
    triplet_t load_val;
    triplet_t held;
    logic     present;
    modport ctl (output load, clear, load_val, input held, present);
    modport store (input load, clear, load_val, output held, present);
endinterface : sense_store_if

// ---- rtl/sense_store.sv ----
// Holds the latest sense triplet
`timescale 1ns/1ps
module sense_store
    import sense_report_pkg::*;
(
    // Clock and reset
    input wire logic   clock,
    input wire logic   rst_n,
    // Store side
    sense_store_if.store st
);
    triplet_t triplet_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            triplet_r <= '0;
        end else if (st.load) begin
            triplet_r <= st.load_val;
        end else if (st.clear) begin
            triplet_r <= '0;
        end
    end

    assign st.held    = triplet_r;
    assign st.present = |triplet_r;
endmodule : sense_store

// ---- rtl/sense_data_report_cmd.sv ----
// Sense report command interpreter with status and result registers
`timescale 1ns/1ps
`include "sense_report_map.svh"
module sense_data_report_cmd
    import sense_report_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    // Command block from host, same clock
    input  wire logic       cmd_valid,
    input  wire logic [7:0] cmd_code,
    input  wire logic [7:0] cmd_devhead,
    input  wire logic [7:0] cmd_log_page,
    output logic            cmd_ready,
    // Other command completion, same clock
    input  wire logic       done_valid,
    input  wire logic       done_error,
    input  wire logic [3:0] done_key,
    input  wire logic [7:0] done_code,
    input  wire logic [7:0] done_qual,
    input  wire logic       drive_ready,
    input  wire logic       index_pulse,
    // Identify word enable bits and reporting enable
    input  wire logic [15:0] ident_w119,
    input  wire logic [15:0] ident_w120,
    input  wire logic       sense_report_enable,
    // Result registers
    output logic [7:0]      command_error_flags,
    output logic [7:0]      device_status_flags,
    output logic [7:0]      sector_number_out,
    output logic [7:0]      cyl_low_out,
    output logic [7:0]      cyl_high_out,
    output logic [7:0]      sector_number_hob,
    output logic [7:0]      cyl_low_hob,
    output logic [7:0]      cyl_high_hob,
    output logic            cmd_done
);
    logic       rst_s1_r;
    logic       rst_n_r;
    cmd_state_t state_r;
    cmd_state_t state_nxt;
    logic       enabled_r;
    logic       abort_r;
    logic [7:0] err_r;
    logic [7:0] stat_r;
    logic [7:0] sn_r;
    logic [7:0] cl_r;
    logic [7:0] ch_r;
    logic       done_r;

    sense_store_if ss();

    sense_store u_store (
        .clock (clock),
        .rst_n (rst_n_r),
        .st    (ss.store)
    );

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    wire is_sense_cmd  = cmd_code == `CMD_SENSE_REPORT;
    wire devhead_ok    = (cmd_devhead & `DEVHEAD_FIXED_MASK) == `DEVHEAD_FIXED_MASK;
    wire reads_err_log = cmd_code == `CMD_READ_LOG_EXT && cmd_log_page == `LOG_PAGE_QUEUED_ERR;
    wire accept        = cmd_valid && cmd_ready;
    wire sense_start   = accept && is_sense_cmd;
    // Both identify bits qualify the status bit; automatic sense plays no part
    wire ident_on      = ident_w119[`IDENT_SENSE_BIT] && ident_w120[`IDENT_SENSE_BIT];
    wire report_on     = enabled_r && ident_on;
    wire triplet_t done_val = '{key: done_key, code: done_code, qual: done_qual};
    wire done_has_sense = |{done_key, done_code, done_qual};

    assign cmd_ready   = state_r == ST_IDLE;
    assign ss.load     = done_valid && state_r == ST_IDLE && !sense_start;
    assign ss.load_val = done_val;
    assign ss.clear    = (accept && !is_sense_cmd && !reads_err_log)
                       || state_r == ST_DONE;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: if (sense_start) state_nxt = ST_EXEC;
            ST_EXEC: state_nxt = ST_DONE;
            ST_DONE: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r   <= ST_IDLE;
            enabled_r <= 1'b0;
            abort_r   <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            enabled_r <= sense_report_enable;
            if (sense_start) abort_r <= !devhead_ok || !enabled_r;
        end
    end

    // Result and status registers
    always_ff @(posedge clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            err_r  <= 8'h00;
            stat_r <= 8'h00;
            sn_r   <= 8'h00;
            cl_r   <= 8'h00;
            ch_r   <= 8'h00;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (state_r == ST_EXEC) begin
                // Empty store yields zeros
                sn_r  <= abort_r ? 8'h00 : ss.held.qual;
                cl_r  <= abort_r ? 8'h00 : ss.held.code;
                ch_r  <= {4'h0, abort_r ? 4'h0 : ss.held.key};
                err_r <= 8'h00;
                err_r[`ERR_ABORT_BIT] <= abort_r;
                stat_r <= 8'h00;
                stat_r[`ST_READY_BIT] <= drive_ready;
                stat_r[`ST_SENSE_BIT] <= index_pulse;
                stat_r[`ST_ERR_BIT]   <= abort_r;
                done_r <= 1'b1;
            end else if (ss.load) begin
                err_r  <= 8'h00;
                err_r[`ERR_ABORT_BIT] <= done_error;
                stat_r <= 8'h00;
                stat_r[`ST_READY_BIT] <= drive_ready;
                stat_r[`ST_SEEK_BIT]  <= 1'b1;
                stat_r[`ST_ERR_BIT]   <= done_error;
                stat_r[`ST_SENSE_BIT] <= report_on && done_has_sense;
            end
        end
    end

    assign command_error_flags = err_r;
    assign device_status_flags = stat_r;
    assign sector_number_out   = sn_r;
    assign cyl_low_out         = cl_r;
    assign cyl_high_out        = ch_r;
    assign sector_number_hob   = 8'h00;
    assign cyl_low_hob         = 8'h00;
    assign cyl_high_hob        = 8'h00;
    assign cmd_done            = done_r;
endmodule : sense_data_report_cmd

// ---- test/sense_data_report_cmd_checker.sv ----
// Port assertions for the sense report block
`timescale 1ns/1ps
module sense_data_report_cmd_checker (
    input wire logic       clock, reset_n, cmd_valid, cmd_ready, cmd_done, drive_ready, index_pulse,
    input wire logic [7:0] cmd_code, cmd_devhead, command_error_flags, device_status_flags, sector_number_out,
    input wire logic [7:0] cyl_low_out, cyl_high_out, sector_number_hob, cyl_low_hob, cyl_high_hob
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence sense_taken; cmd_valid && cmd_ready && cmd_code == 8'h0b; endsequence
    sequence bad_head; sense_taken ##0 cmd_devhead[7:5] != 3'b111; endsequence
    done_two_a: assert property (sense_taken |-> ##2 cmd_done) else $error("late completion");
    busy_hold_a: assert property (sense_taken |=> !cmd_ready [*2] ##1 cmd_ready) else $error("ready");
    head_abort_a: assert property (bad_head |-> ##2 command_error_flags[2] && device_status_flags[0]
        && {cyl_high_out, cyl_low_out, sector_number_out} == 24'h0) else $error("no abort");
    err_only_a: assert property (cmd_done |-> (command_error_flags & 8'hfb) == 8'h00) else $error("err");
    st_zero_a: assert property (cmd_done |-> (device_status_flags & 8'ha4) == 8'h00) else $error("st");
    rdy_copy_a: assert property (cmd_done |-> device_status_flags[6] == $past(drive_ready)) else $error("rdy");
    idx_copy_a: assert property (cmd_done |-> device_status_flags[1] == $past(index_pulse)) else $error("idx");
    hob_zero_a: assert property (cmd_done |-> cyl_high_out[7:4] == 4'h0
        && {sector_number_hob, cyl_low_hob, cyl_high_hob} == 24'h0) else $error("hob");
endmodule : sense_data_report_cmd_checker
bind sense_data_report_cmd sense_data_report_cmd_checker u_sense_data_report_cmd_checker (.*);

// ---- test/sense_host_model.sv ----
// Host side that offers one command block at a time
`timescale 1ns/1ps
module sense_host_model (
    input  wire logic       clock,
    input  wire logic       start,
    input  wire logic       good,
    input  wire logic [7:0] code,
    input  wire logic [7:0] page,
    input  wire logic       cmd_ready,
    output logic            cmd_valid = 1'b0,
    output logic [7:0]      cmd_code = 8'h00,
    output logic [7:0]      cmd_devhead = 8'h00,
    output logic [7:0]      cmd_log_page = 8'h00
);
    always @(posedge clock) begin
        if (start) begin
            cmd_valid <= 1'b1;
            cmd_code <= code;
            cmd_devhead <= good ? 8'he0 : 8'h60;
            cmd_log_page <= page;
        end else if (cmd_valid && cmd_ready) begin
            cmd_valid <= 1'b0;
            cmd_code <= ~cmd_code;
            cmd_devhead <= ~cmd_devhead;
        end
    end
endmodule : sense_host_model

// ---- test/test_sense_data_report_cmd.sv ----
// Self-checking bench for the sense report block
`timescale 1ns/1ps
module test_sense_data_report_cmd;
    import sense_report_pkg::*;
    logic clock = 0, reset_n = 0, start = 0, good = 1, done_valid = 0, done_error = 0;
    logic drive_ready = 1, index_pulse = 0, sense_report_enable = 0, cmd_valid, cmd_ready, cmd_done;
    logic [7:0] code = 8'h0b, page = 8'h00, cmd_code, cmd_devhead, cmd_log_page, err, st, sn, cl, ch;
    logic [15:0] ident_w119 = 16'h0040, ident_w120 = 16'h0040;
    triplet_t t_in = '0;
    int miscompares = 0, compares = 0;
    initial forever #25 clock = ~clock;
    sense_host_model u_sense_host_model (.clock, .start, .good, .code, .page, .cmd_ready, .cmd_valid, .cmd_code,
        .cmd_devhead, .cmd_log_page);
    sense_data_report_cmd u_sense_data_report_cmd (.clock, .reset_n, .cmd_valid, .cmd_code, .cmd_devhead,
        .cmd_log_page, .cmd_ready, .done_valid, .done_error, .done_key(t_in.key), .done_code(t_in.code),
        .done_qual(t_in.qual), .drive_ready, .index_pulse, .ident_w119, .ident_w120, .sense_report_enable,
        .command_error_flags(err), .device_status_flags(st), .sector_number_out(sn), .cyl_low_out(cl),
        .cyl_high_out(ch), .sector_number_hob(), .cyl_low_hob(), .cyl_high_hob(), .cmd_done);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude;
        if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    task automatic issue(input logic [7:0] c, input logic [7:0] pg);
        @(posedge clock);
        code <= c;
        page <= pg;
        start <= 1;
        @(posedge clock);
        start <= 0;
        repeat (5) @(posedge clock);
    endtask : issue
    task automatic complete(input triplet_t t, input logic e);
        @(posedge clock);
        t_in <= t;
        done_error <= e;
        done_valid <= 1;
        @(posedge clock);
        done_valid <= 0;
        repeat (2) @(posedge clock);
    endtask : complete
    // Sense report, then compare triplet fields and abort indication
    task automatic report(input logic [19:0] exp, input logic ab);
        issue(8'h0b, 8'h00);
        check({ch, cl, sn}, {4'h0, exp});
        check({err, st[0]}, {5'h0, ab, 2'h0, ab});
    endtask : report
    initial begin
        repeat (3) @(posedge clock);
        reset_n <= 1;
        repeat (4) @(posedge clock);
        complete(20'h52401, 0);
        report(20'h0, 1);
        sense_report_enable <= 1;
        complete(20'h31100, 1);
        check(st[1:0], 2'b11);
        report(20'h31100, 0);
        report(20'h0, 0);
        complete(20'h52401, 0);
        complete(20'h62907, 0);
        report(20'h62907, 0);
        complete(20'h62907, 0);
        issue(8'h2f, 8'h10);
        report(20'h62907, 0);
        complete(20'h62907, 0);
        issue(8'h25, 8'h00);
        report(20'h0, 0);
        good <= 0;
        drive_ready <= 0;
        index_pulse <= 1;
        report(20'h0, 1);
        good <= 1;
        ident_w120 <= 16'h0000;
        complete(20'h62907, 0);
        check(st[1], 1'b0);
        conclude();
    end
    initial begin
        #50us;
        miscompares++;
        conclude();
    end
endmodule : test_sense_data_report_cmd
